// ==== cft_cfg.svh ====
// Register map, field positions, reset values and counts of the CAN filter,
// time-stamp and overflow block. Pure definitions, no logic.
// Assumes inclusion by bare name from the package and the core.
// Operation
// - Sixteen message FIFOs, sixteen messages each
// - Each FIFO set as transmit or receive
// - Transmit FIFOs arbitrated by software priority
// - Sixteen filters, each picks one of four masks
// - Remote request answered automatically by hardware
// - Loopback, listen-all and listen-only modes
// - Programmable bit rate, CAN 2.0B framing
// - Block masters system bus for message memory
// - Data-only reception mode stores payload only
// - Overflow status: sixteen read-only flags, upper zero
// - Free-running stamp advances every prescale clocks
// - Prescale zero every clock, ones every 65535
// - Timer: stamp high half, prescale low half
// - Stamp holds while capture enable clear
// - Timer write restarts prescale count, setting kept
// - Per-filter enable bit, lane bit seven
// - Two-bit mask choice selects mask zero..three
// - Five-bit destination, codes sixteen up reserved
// - One byte lane per filter
// - Mask and destination writable only while disabled
// - Upper filter registers repeat same lane layout
`ifndef CFT_CFG_SVH
`define CFT_CFG_SVH

// Register offsets (byte addresses)
`define CFT_OFF_OVF 8'h00
`define CFT_OFF_TMR 8'h04
`define CFT_OFF_FLT 8'h08
`define CFT_OFF_MASK 8'h18
`define CFT_OFF_FID 8'h28
`define CFT_OFF_CTRL 8'h68
`define CFT_OFF_MBASE 8'h6C
`define CFT_OFF_FCFG 8'h80

// Control register fields
`define CFT_CTRL_MODE_LSB 0
`define CFT_CTRL_DONLY 2
`define CFT_CTRL_BRP_LSB 8
`define CFT_CTRL_CAP 20

// FIFO configuration register fields
`define CFT_FCFG_TX 0
`define CFT_FCFG_PRIO_LSB 1
`define CFT_FCFG_TXREQ 3
`define CFT_FCFG_AUTO 4
`define CFT_FCFG_PUSH 5
`define CFT_FCFG_POP 6
`define CFT_FCFG_OVCLR 7
`define CFT_FCFG_CNT_LSB 8
`define CFT_FCFG_FULL 16

// Filter lane fields, relative to the lane's low bit
`define CFT_LANE_EN 7
`define CFT_LANE_MASK_CHOICE_LSB 5
`define CFT_LANE_DEST_LSB 0

// Reset values
`define CFT_RST_WORD 32'h0000_0000
`define CFT_RST_CTRL 32'h0000_0000

// Memory layout: four words per message
`define CFT_MSG_WORDS 4
`define CFT_WORD_DATA 2

`endif

// ==== cft_pkg.sv ====
// Types shared by the CAN filter, time-stamp and overflow block.
// Assumes cft_cfg.svh sits in the same folder.
`default_nettype none
package cft_pkg;
  `include "cft_cfg.svh"

  // Operating modes
  typedef enum logic [1:0] {
    CFT_NORMAL,
    CFT_LOOPBACK,
    CFT_LISTEN_ALL,
    CFT_LISTEN_ONLY
  } cft_mode_t;

  // Message engine states
  typedef enum logic [1:0] {
    CFT_IDLE,
    CFT_RXWR,
    CFT_TXRD,
    CFT_TXSEND
  } cft_state_t;
endpackage
`default_nettype wire

// ==== cft_core.sv ====
// CAN filter, FIFO, time-stamp and overflow core.
// Assumes a bit engine outside that hands over whole frames and sends whole
// frames, a register port with read data one cycle later, and a memory slave.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cft_cfg.svh"
module cft_core #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Received frames from the bit engine
  input wire logic rxFrameValid,
  input wire logic [28:0] rxId,
  input wire logic rxIde,
  input wire logic rxRtr,
  input wire logic [3:0] rxDlc,
  input wire logic [63:0] rxData,
  output logic rxReady,
  // Frames to the bit engine
  output logic txFrameValid,
  output logic [28:0] txId,
  output logic txIde,
  output logic txRtr,
  output logic [3:0] txDlc,
  output logic [63:0] txData,
  input wire logic txDone,
  output logic [7:0] bitRatePrescale,
  output logic listenOnly,
  // System bus master
  output logic [31:0] memAddr,
  output logic [31:0] memWrData,
  output logic memWrite,
  output logic memRead,
  input wire logic [31:0] memRdData,
  input wire logic memReady
);
  import cft_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [31:0] ctrl_reg, ctrl_next; // Mode, capture, bit rate
  logic [31:0] memBase_reg, memBase_next; // Message area base
  logic [29:0] mask_reg [4], mask_next [4]; // Acceptance masks
  logic [29:0] fltId_reg [16], fltId_next [16]; // Filter identifiers
  logic [15:0] filter_enable_reg, filter_enable_next; // Filter enables
  logic [1:0] fltMsel_reg [16], fltMsel_next [16]; // Mask choice per filter
  logic [4:0] fltDest_reg [16], fltDest_next [16]; // Destination per filter
  logic [31:0] regRdData_reg, regRdData_next;
  logic wrCtrl, wrBase, wrTmr;
  cft_mode_t mode;
  logic dataOnly, capEn;

  assign wrCtrl = regWrite && regAddr == `CFT_OFF_CTRL;
  assign wrBase = regWrite && regAddr == `CFT_OFF_MBASE;
  assign wrTmr = regWrite && regAddr == `CFT_OFF_TMR;
  assign mode = cft_mode_t'(ctrl_reg[`CFT_CTRL_MODE_LSB +: 2]);
  assign dataOnly = ctrl_reg[`CFT_CTRL_DONLY];
  assign capEn = ctrl_reg[`CFT_CTRL_CAP];

  // Control, base and mask registers; base kept 4 KiB aligned for the slot layout
  always_comb begin
    ctrl_next = wrCtrl ? regWrData : ctrl_reg;
    memBase_next = wrBase ? {regWrData[31:12], 12'h000} : memBase_reg;
    for (int m = 0; m < 4; m++) begin
      mask_next[m] = (regWrite && regAddr == `CFT_OFF_MASK + 8'(4 * m)) ? regWrData[29:0] : mask_reg[m];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `CFT_RST_CTRL;
      memBase_reg <= `CFT_RST_WORD;
      for (int m = 0; m < 4; m++) mask_reg[m] <= 30'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      memBase_reg <= memBase_next;
      for (int m = 0; m < 4; m++) mask_reg[m] <= mask_next[m];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filters: one byte lane each, four lanes per control register
  logic [15:0] fltHit;
  logic [29:0] rxKey; // {ide, id} of frame in hand

  genvar gf;
  generate
    for (gf = 0; gf < 16; gf++) begin : g_flt
      localparam int LANE = (gf % 4) * 8;
      logic wrLane;
      assign wrLane = regWrite && regAddr == `CFT_OFF_FLT + 8'(4 * (gf / 4));
      always_comb begin
        filter_enable_next[gf] = wrLane ? regWrData[LANE + `CFT_LANE_EN] : filter_enable_reg[gf];
        fltId_next[gf] = (regWrite && regAddr == `CFT_OFF_FID + 8'(4 * gf)) ? regWrData[29:0] : fltId_reg[gf];
        // Fields only move while the filter is off, so a live match never sees a torn setting
        if (wrLane && !filter_enable_reg[gf]) begin
          fltMsel_next[gf] = regWrData[LANE + `CFT_LANE_MASK_CHOICE_LSB +: 2];
          fltDest_next[gf] = regWrData[LANE + `CFT_LANE_DEST_LSB +: 5];
        end else begin
          fltMsel_next[gf] = fltMsel_reg[gf];
          fltDest_next[gf] = fltDest_reg[gf];
        end
      end
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          filter_enable_reg[gf] <= 1'b0;
          fltId_reg[gf] <= 30'h0000_0000;
          fltMsel_reg[gf] <= 2'h0;
          fltDest_reg[gf] <= 5'h00;
        end else begin
          filter_enable_reg[gf] <= filter_enable_next[gf];
          fltId_reg[gf] <= fltId_next[gf];
          fltMsel_reg[gf] <= fltMsel_next[gf];
          fltDest_reg[gf] <= fltDest_next[gf];
        end
      end
      // Masked compare against the chosen acceptance mask
      assign fltHit[gf] = filter_enable_reg[gf] && (((rxKey ^ fltId_reg[gf]) & mask_reg[fltMsel_reg[gf]]) == 30'h0000_0000);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Time-stamp timer
  logic [15:0] stamp_reg, stamp_next; // stamp_count
  logic [15:0] prescale_reg, prescale_next; // stamp_prescale
  logic [15:0] pscCnt_reg, pscCnt_next; // Internal prescale count
  logic [15:0] pscLimit;

  // Setting zero and one both give a tick every clock
  assign pscLimit = (prescale_reg == 16'h0000) ? 16'h0000 : prescale_reg - 16'h0001;

  always_comb begin
    stamp_next = stamp_reg;
    prescale_next = prescale_reg;
    pscCnt_next = pscCnt_reg;
    if (capEn) begin
      if (pscCnt_reg >= pscLimit) begin
        pscCnt_next = 16'h0000;
        stamp_next = stamp_reg + 16'h0001;
      end else begin
        pscCnt_next = pscCnt_reg + 16'h0001;
      end
    end
    // Software write wins and restarts the prescale count
    if (wrTmr) begin
      stamp_next = regWrData[31:16];
      prescale_next = regWrData[15:0];
      pscCnt_next = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stamp_reg <= 16'h0000;
      prescale_reg <= 16'h0000;
      pscCnt_reg <= 16'h0000;
    end else begin
      stamp_reg <= stamp_next;
      prescale_reg <= prescale_next;
      pscCnt_reg <= pscCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO state and message engine
  cft_state_t state_reg, state_next;
  logic [4:0] cnt_reg [16], cnt_next [16]; // Messages held
  logic [3:0] head_reg [16], head_next [16]; // Oldest slot
  logic [3:0] tail_reg [16], tail_next [16]; // Next free slot
  logic [15:0] ovf_reg, ovf_next; // fifo_overrun_flag
  logic [15:0] isTx_reg, isTx_next; // FIFO direction
  logic [1:0] prio_reg [16], prio_next [16]; // Transmit priority
  logic [15:0] txReq_reg, txReq_next; // Transmit requested
  logic [15:0] auto_reg, auto_next; // Answers remote requests
  logic [3:0] fifo_reg, fifo_next; // FIFO in service
  logic [1:0] word_reg, word_next; // Word in service
  logic [31:0] msg_reg [4], msg_next [4]; // Message being moved
  logic loopPend_reg, loopPend_next; // Looped frame waiting
  logic txValid_reg, txValid_next;
  logic memWrite_reg, memWrite_next;
  logic memRead_reg, memRead_next;
  logic [31:0] memAddr_reg, memAddr_next;
  logic rxReady_reg, rxReady_next;
  logic [15:0] incV, decV, swPush, swPop, ovSet, ovClr;
  logic [3:0] txPick;
  logic txAny;
  logic [1:0] txBest;
  logic [31:0] inWord [4];
  logic [3:0] hitIdx;
  logic hitAny;
  logic [4:0] dest;
  logic rxTake;

  // Frame in hand: looped-back frame first, else the bit engine's frame
  always_comb begin
    if (loopPend_reg) begin
      inWord[0] = msg_reg[0];
      inWord[1] = {stamp_reg, msg_reg[1][15:0]};
      inWord[2] = msg_reg[2];
      inWord[3] = msg_reg[3];
    end else begin
      inWord[0] = {rxIde, rxRtr, 1'b0, rxId};
      inWord[1] = {stamp_reg, 12'h000, rxDlc};
      inWord[2] = rxData[31:0];
      inWord[3] = rxData[63:32];
    end
  end
  assign rxKey = {inWord[0][31], inWord[0][28:0]};
  assign rxTake = loopPend_reg || (rxFrameValid && rxReady_reg);

  // Lowest-numbered matching filter decides; listen-all sends all to FIFO 0
  always_comb begin
    hitIdx = 4'h0;
    hitAny = 1'b0;
    for (int f = 15; f >= 0; f--) begin
      if (fltHit[f]) begin
        hitIdx = 4'(f);
        hitAny = 1'b1;
      end
    end
    if (mode == CFT_LISTEN_ALL) begin
      dest = 5'h00;
    end else begin
      dest = hitAny ? fltDest_reg[hitIdx] : 5'h10;
    end
  end

  // Highest priority pending transmit FIFO, ties to the lowest number
  always_comb begin
    txPick = 4'h0;
    txAny = 1'b0;
    txBest = 2'h0;
    for (int i = 0; i < 16; i++) begin
      if (isTx_reg[i] && txReq_reg[i] && cnt_reg[i] != 5'h00 && (!txAny || prio_reg[i] > txBest)) begin
        txPick = 4'(i);
        txAny = 1'b1;
        txBest = prio_reg[i];
      end
    end
  end

  // Software FIFO commands
  generate
    for (gf = 0; gf < 16; gf++) begin : g_cmd
      logic wrCfg;
      assign wrCfg = regWrite && regAddr == `CFT_OFF_FCFG + 8'(4 * gf);
      assign swPush[gf] = wrCfg && regWrData[`CFT_FCFG_PUSH] && cnt_reg[gf] != 5'(FIFO_DEPTH);
      assign swPop[gf] = wrCfg && regWrData[`CFT_FCFG_POP] && cnt_reg[gf] != 5'h00;
      assign ovClr[gf] = wrCfg && regWrData[`CFT_FCFG_OVCLR];
    end
  endgenerate

  // Engine next state
  always_comb begin
    state_next = state_reg;
    fifo_next = fifo_reg;
    word_next = word_reg;
    loopPend_next = loopPend_reg;
    txValid_next = txValid_reg;
    incV = 16'h0000;
    decV = 16'h0000;
    ovSet = 16'h0000;
    isTx_next = isTx_reg;
    txReq_next = txReq_reg;
    auto_next = auto_reg;
    for (int i = 0; i < 4; i++) msg_next[i] = msg_reg[i];
    for (int i = 0; i < 16; i++) begin
      prio_next[i] = prio_reg[i];
      if (regWrite && regAddr == `CFT_OFF_FCFG + 8'(4 * i)) begin
        isTx_next[i] = regWrData[`CFT_FCFG_TX];
        prio_next[i] = regWrData[`CFT_FCFG_PRIO_LSB +: 2];
        txReq_next[i] = regWrData[`CFT_FCFG_TXREQ];
        auto_next[i] = regWrData[`CFT_FCFG_AUTO];
      end
    end
    case (state_reg)
      CFT_IDLE: begin
        if (rxTake) begin
          loopPend_next = 1'b0;
          // Reserved destinations drop the frame
          if (!dest[4]) begin
            fifo_next = dest[3:0];
            if (isTx_reg[dest[3:0]]) begin
              // Remote request hitting a reply FIFO queues its stored answer
              if (inWord[0][30] && auto_reg[dest[3:0]]) begin
                txReq_next[dest[3:0]] = 1'b1;
              end
            end else if (cnt_reg[dest[3:0]] == 5'(FIFO_DEPTH)) begin
              ovSet[dest[3:0]] = 1'b1;
            end else begin
              for (int i = 0; i < 4; i++) msg_next[i] = inWord[i];
              word_next = dataOnly ? 2'(`CFT_WORD_DATA) : 2'h0;
              state_next = CFT_RXWR;
            end
          end
        end else if (txAny && mode != CFT_LISTEN_ONLY) begin
          fifo_next = txPick;
          word_next = 2'h0;
          state_next = CFT_TXRD;
        end
      end
      CFT_RXWR: begin
        if (memReady) begin
          word_next = word_reg + 2'h1;
          if (word_reg == 2'(`CFT_MSG_WORDS - 1)) begin
            incV[fifo_reg] = 1'b1;
            state_next = CFT_IDLE;
          end
        end
      end
      CFT_TXRD: begin
        if (memReady) begin
          msg_next[word_reg] = memRdData;
          word_next = word_reg + 2'h1;
          if (word_reg == 2'(`CFT_MSG_WORDS - 1)) begin
            state_next = CFT_TXSEND;
            // Loopback never reaches the bus; the frame returns as a receive
            if (mode == CFT_LOOPBACK) begin
              loopPend_next = 1'b1;
            end else begin
              txValid_next = 1'b1;
            end
          end
        end
      end
      CFT_TXSEND: begin
        if (loopPend_reg || txDone) begin
          txValid_next = 1'b0;
          decV[fifo_reg] = 1'b1;
          if (cnt_reg[fifo_reg] == 5'h01) txReq_next[fifo_reg] = 1'b0;
          state_next = CFT_IDLE;
        end
      end
      default: state_next = CFT_IDLE;
    endcase
    // Counters and pointers: engine and software may act together
    for (int i = 0; i < 16; i++) begin
      tail_next[i] = tail_reg[i] + 4'(incV[i] | (isTx_reg[i] & swPush[i]));
      head_next[i] = head_reg[i] + 4'(decV[i] | (!isTx_reg[i] & swPop[i]));
      cnt_next[i] = cnt_reg[i] + 5'(incV[i] | (isTx_reg[i] & swPush[i]))
                    - 5'(decV[i] | (!isTx_reg[i] & swPop[i]));
    end
    // A new overflow wins over a clear in the same cycle
    ovf_next = (ovf_reg & ~ovClr) | ovSet;
    // Bus request and address for the coming cycle
    memWrite_next = state_next == CFT_RXWR;
    memRead_next = state_next == CFT_TXRD;
    memAddr_next = {memBase_reg[31:12], fifo_next,
                    (state_next == CFT_RXWR) ? tail_reg[fifo_next] : head_reg[fifo_next], word_next, 2'b00};
    rxReady_next = state_next == CFT_IDLE && !loopPend_next;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CFT_IDLE;
      fifo_reg <= 4'h0;
      word_reg <= 2'h0;
      loopPend_reg <= 1'b0;
      txValid_reg <= 1'b0;
      ovf_reg <= 16'h0000;
      isTx_reg <= 16'h0000;
      txReq_reg <= 16'h0000;
      auto_reg <= 16'h0000;
      memWrite_reg <= 1'b0;
      memRead_reg <= 1'b0;
      memAddr_reg <= 32'h0000_0000;
      rxReady_reg <= 1'b0;
      for (int i = 0; i < 4; i++) msg_reg[i] <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) begin
        cnt_reg[i] <= 5'h00;
        head_reg[i] <= 4'h0;
        tail_reg[i] <= 4'h0;
        prio_reg[i] <= 2'h0;
      end
    end else begin
      state_reg <= state_next;
      fifo_reg <= fifo_next;
      word_reg <= word_next;
      loopPend_reg <= loopPend_next;
      txValid_reg <= txValid_next;
      ovf_reg <= ovf_next;
      isTx_reg <= isTx_next;
      txReq_reg <= txReq_next;
      auto_reg <= auto_next;
      memWrite_reg <= memWrite_next;
      memRead_reg <= memRead_next;
      memAddr_reg <= memAddr_next;
      rxReady_reg <= rxReady_next;
      for (int i = 0; i < 4; i++) msg_reg[i] <= msg_next[i];
      for (int i = 0; i < 16; i++) begin
        cnt_reg[i] <= cnt_next[i];
        head_reg[i] <= head_next[i];
        tail_reg[i] <= tail_next[i];
        prio_reg[i] <= prio_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read-back, one cycle after the strobe; unmapped reads give zero
  always_comb begin
    regRdData_next = 32'h0000_0000;
    if (regRead) begin
      if (regAddr == `CFT_OFF_OVF) begin
        regRdData_next = {16'h0000, ovf_reg};
      end else if (regAddr == `CFT_OFF_TMR) begin
        regRdData_next = {stamp_reg, prescale_reg};
      end else if (regAddr == `CFT_OFF_CTRL) begin
        regRdData_next = ctrl_reg;
      end else if (regAddr == `CFT_OFF_MBASE) begin
        regRdData_next = memBase_reg;
      end
      for (int k = 0; k < 4; k++) begin
        if (regAddr == `CFT_OFF_MASK + 8'(4 * k)) regRdData_next = {2'b00, mask_reg[k]};
        if (regAddr == `CFT_OFF_FLT + 8'(4 * k)) begin
          for (int l = 0; l < 4; l++) begin
            regRdData_next[8 * l +: 8] = {filter_enable_reg[4 * k + l], fltMsel_reg[4 * k + l], fltDest_reg[4 * k + l]};
          end
        end
      end
      for (int k = 0; k < 16; k++) begin
        if (regAddr == `CFT_OFF_FID + 8'(4 * k)) regRdData_next = {2'b00, fltId_reg[k]};
        if (regAddr == `CFT_OFF_FCFG + 8'(4 * k)) begin
          regRdData_next = {15'h0000, cnt_reg[k] == 5'(FIFO_DEPTH), 3'b000, cnt_reg[k], 3'b000,
                            auto_reg[k], txReq_reg[k], prio_reg[k], isTx_reg[k]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) regRdData_reg <= 32'h0000_0000;
    else regRdData_reg <= regRdData_next;
  end

  // Outputs from flops; memWrData muxed by word_reg, listenOnly decoded from the mode bits
  assign regRdData = regRdData_reg;
  assign rxReady = rxReady_reg;
  assign txFrameValid = txValid_reg;
  assign txId = msg_reg[0][28:0];
  assign txIde = msg_reg[0][31];
  assign txRtr = msg_reg[0][30];
  assign txDlc = msg_reg[1][3:0];
  assign txData = {msg_reg[3], msg_reg[2]};
  assign bitRatePrescale = ctrl_reg[`CFT_CTRL_BRP_LSB +: 8];
  assign listenOnly = ctrl_reg[`CFT_CTRL_MODE_LSB +: 2] == 2'(CFT_LISTEN_ONLY);
  assign memAddr = memAddr_reg;
  assign memWrData = msg_reg[word_reg];
  assign memWrite = memWrite_reg;
  assign memRead = memRead_reg;
endmodule // cft_core
`default_nettype wire

// ==== cft_core_chk.sv ====
// Port checker for cft_core: register port, frame and memory handshakes.
// Assumes one clock domain and bind onto every cft_core instance.
`timescale 1ns/10ps
`default_nettype none
`include "cft_cfg.svh"
module cft_core_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic txFrameValid,
  input wire logic [28:0] txId,
  input wire logic txDone,
  input wire logic listenOnly,
  input wire logic [31:0] memAddr,
  input wire logic memWrite,
  input wire logic memReady
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  // Register steps: filter read, write, read again; timer write
  sequence flt_rd; regRead && regAddr == `CFT_OFF_FLT; endsequence
  sequence flt_wr; regWrite && regAddr == `CFT_OFF_FLT; endsequence
  sequence tmr_wr; regWrite && regAddr == `CFT_OFF_TMR; endsequence
  rd_idle_a: assert property (!regRead |=> regRdData == 32'h0000_0000)
    else $error("read data not zero outside read");
  ovf_upper_a: assert property (regRead && regAddr == `CFT_OFF_OVF |=> regRdData[31:16] == 16'h0000)
    else $error("overflow upper half not zero");
  tmr_pre_a: assert property (tmr_wr ##1 regRead && regAddr == `CFT_OFF_TMR
    |=> regRdData[15:0] == $past(regWrData[15:0], 2))
    else $error("prescale setting lost");
  flt_en_a: assert property (flt_wr ##1 flt_rd |=> regRdData[7] == $past(regWrData[7], 2))
    else $error("filter enable not written");
  flt_free_a: assert property (flt_rd ##1 (flt_wr and !regRdData[7]) ##1 flt_rd
    |=> regRdData[7:0] == $past(regWrData[7:0], 2))
    else $error("disabled filter lane not written");
  flt_lock_a: assert property (flt_rd ##1 (flt_wr and regRdData[7]) ##1 flt_rd
    |=> regRdData[6:0] == $past(regRdData[6:0], 2))
    else $error("enabled filter lane changed");
  tx_hold_a: assert property (txFrameValid && !txDone |=> txFrameValid && $stable(txId))
    else $error("frame dropped before done");
  mem_hold_a: assert property (memWrite && !memReady |=> memWrite && $stable(memAddr))
    else $error("memory write not held");
  lo_tx_a: assert property ($rose(txFrameValid) |-> !listenOnly)
    else $error("frame started in listen-only");
endmodule // cft_core_chk
bind cft_core cft_core_chk chk_u (.*);
`default_nettype wire

// ==== cft_bus_model.sv ====
// Far-side model: message memory slave and frame sender.
// Assumes the core holds requests until memReady and frames until txDone.
`timescale 1ns/10ps
`default_nettype none
module cft_bus_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [31:0] memAddr,
  input wire logic memWrite,
  input wire logic memRead,
  output logic [31:0] memRdData,
  output logic memReady,
  input wire logic txFrameValid,
  output logic txDone,
  output int nWrites
);
  logic slow; // Next answer waits one cycle
  logic [1:0] tcnt; // Cycles the frame has been on the wire
  // Answers alternate prompt and slow; data is the address, else its inverse
  assign memReady = (memWrite || memRead) && !slow;
  assign memRdData = (memRead && memReady) ? memAddr : ~memAddr;
  assign txDone = (tcnt == 2'd3);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slow <= 1'b0;
      tcnt <= 2'd0;
      nWrites <= 0;
    end else begin
      slow <= (memWrite || memRead) && !slow;
      tcnt <= (txFrameValid && !txDone) ? tcnt + 2'd1 : 2'd0;
      if (memWrite && memReady) begin
        nWrites <= nWrites + 1;
      end
    end
  end
endmodule // cft_bus_model
`default_nettype wire

// ==== cft_core_tb.sv ====
// Bench for cft_core: registers, time stamp, filters, receive overflow, send.
// Assumes cft_bus_model on the far side and the checker bound in.
`timescale 1ns/10ps
`default_nettype none
`include "cft_cfg.svh"
module cft_core_tb;
  logic clk_sys, reset_n, regWrite, regRead, rxFrameValid, rxReady, listenOnly;
  logic txFrameValid, txDone, memWrite, memRead, memReady;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, got, s0, w, memAddr, memWrData, memRdData;
  logic [63:0] txData;
  int failures = 0, n_checks = 0, cyc = 0, nWrites;
  cft_core dut_u (.*, .rxId(29'h0000_0123), .rxIde(1'b0), .rxRtr(1'b0), .rxDlc(4'h8),
    .rxData(64'h0123_4567_89AB_CDEF), .txId(), .txIde(), .txRtr(), .txDlc(), .bitRatePrescale());
  cft_bus_model far_u (.*);
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Read data stands one cycle; catch it mid-cycle
  always @(negedge clk_sys) got <= regRdData;
  // Hang guard, far above the run's length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end
  // One register cycle; strobes change only right after an edge
  task automatic bus(input logic r, input logic wr, input logic [7:0] a, input logic [31:0] d);
    regRead <= r;
    regWrite <= wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b1, 1'b0, a, 32'h0000_0000);
    idle(1);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Stamp steps seen between two reads n cycles apart
  task automatic rate(input logic [15:0] pre, input int n, input logic [15:0] e);
    bus(1'b0, 1'b1, `CFT_OFF_TMR, {16'h0000, pre});
    rd(`CFT_OFF_TMR);
    s0 = got;
    idle(n - 2);
    rd(`CFT_OFF_TMR);
    chk({16'h0000, got[31:16] - s0[31:16]}, {16'h0000, e});
    chk({16'h0000, got[15:0]}, {16'h0000, pre});
  endtask
  // Frame held until taken, then released for a cycle
  task automatic send();
    rxFrameValid <= 1'b1;
    do @(posedge clk_sys); while (rxReady !== 1'b1);
    rxFrameValid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, regWrite, regRead, rxFrameValid, regAddr, regWrData} = '0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 1'b1, `CFT_OFF_OVF, 32'hFFFF_FFFF);
    bus(1'b0, 1'b1, 8'hFC, 32'hFFFF_FFFF);
    rd(`CFT_OFF_OVF);
    chk(got, 32'h0000_0000);
    rd(8'hFC);
    chk(got, 32'h0000_0000);
    rd(`CFT_OFF_TMR);
    chk(got, 32'h0000_0000);
    $display("reset test done");
    bus(1'b0, 1'b1, `CFT_OFF_CTRL, 32'h0010_0000);
    rate(16'h0000, 20, 16'h0014);
    rate(16'h0004, 40, 16'h000A);
    rate(16'hFFFF, 40, 16'h0000);
    bus(1'b0, 1'b1, `CFT_OFF_CTRL, 32'h0000_0000);
    rate(16'h0004, 40, 16'h0000);
    bus(1'b0, 1'b1, `CFT_OFF_CTRL, 32'h0010_0000);
    bus(1'b0, 1'b1, `CFT_OFF_TMR, 32'h0000_0008);
    idle(4);
    bus(1'b0, 1'b1, `CFT_OFF_TMR, 32'h0000_0008);
    idle(5);
    rd(`CFT_OFF_TMR);
    chk(got, 32'h0000_0008);
    $display("stamp test done");
    for (int f = 0; f < 4; f++) begin
      w = 32'h6040_2000 | (32'h0302_0100 + 32'h0101_0101 * (4 * f));
      bus(1'b1, 1'b0, `CFT_OFF_FLT + 8'(4 * f), 32'h0000_0000);
      bus(1'b0, 1'b1, `CFT_OFF_FLT + 8'(4 * f), w);
      rd(`CFT_OFF_FLT + 8'(4 * f));
      chk(got, w);
    end
    bus(1'b0, 1'b1, `CFT_OFF_FLT, 32'h6342_2180);
    bus(1'b1, 1'b0, `CFT_OFF_FLT, 32'h0000_0000);
    bus(1'b0, 1'b1, `CFT_OFF_FLT, 32'h7C5D_3E9F);
    rd(`CFT_OFF_FLT);
    chk(got, 32'h7C5D_3E80);
    $display("filter test done");
    repeat (17) send();
    idle(4);
    chk(32'(nWrites), 32'd64);
    rd(`CFT_OFF_FCFG);
    chk(got, 32'h0001_1000);
    rd(`CFT_OFF_OVF);
    chk(got, 32'h0000_0001);
    bus(1'b0, 1'b1, `CFT_OFF_FCFG, 32'h0000_0080);
    rd(`CFT_OFF_OVF);
    chk(got, 32'h0000_0000);
    $display("receive test done");
    bus(1'b0, 1'b1, `CFT_OFF_FCFG + 8'h14, 32'h0000_0001);
    bus(1'b0, 1'b1, `CFT_OFF_FCFG + 8'h14, 32'h0000_0021);
    bus(1'b0, 1'b1, `CFT_OFF_FCFG + 8'h14, 32'h0000_0009);
    while (txFrameValid !== 1'b1) idle(1);
    chk(txData[31:0], 32'h0000_0508);
    while (txFrameValid === 1'b1) idle(1);
    rd(`CFT_OFF_FCFG + 8'h14);
    chk(got, 32'h0000_0001);
    bus(1'b0, 1'b1, `CFT_OFF_CTRL, 32'h0000_0003);
    idle(1);
    chk({31'h0, listenOnly}, 32'h0000_0001);
    $display("send test done");
    wrap_up();
  end
endmodule // cft_core_tb
`default_nettype wire
